// >>> hdl/lljl_core.sv
// Purpose: loss of signal supervision, jitter attenuator placement and line loopbacks
// Assumes: line, framer and clock pins are asynchronous to clk_i and slow against it
// Notes: registers at word offsets 0 to 2, reads answer one cycle later
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lljl_regs.svh"

module lljl_core #(
    parameter int JA_DEPTH = 128
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [15:0] reg_rdata_o,
    input wire logic rx_line_in_p_i,
    input wire logic rx_line_in_n_i,
    input wire logic rx_clock_i,
    input wire logic [5:0] rx_level_db_i,
    input wire lljl_pkg::lljl_rail_t tx_rail_i,
    input wire logic tx_clock_in_i,
    input wire logic master_clock_i,
    output lljl_pkg::lljl_rail_t rx_serial_data_o,
    output logic rx_clock_o,
    output logic tx_line_out_p_o,
    output logic tx_line_out_n_o,
    output logic tx_line_clock_o,
    output logic rx_carrier_loss_o
);
    import lljl_pkg::*;

    // ==========================================================
    // helpers
    // sensitivity is forced into the short or long haul band; there is no haul bit
    function automatic logic [5:0] sens_clamp(input logic [5:0] s, input logic e1);
        logic [5:0] lh_max;
        lh_max = e1 ? `LLJL_SENS_LH_E1_MAX : `LLJL_SENS_LH_T1_MAX;
        if (s < `LLJL_SENS_SH_MIN) begin
            sens_clamp = `LLJL_SENS_SH_MIN;
        end else if (s > `LLJL_SENS_SH_MAX && s < `LLJL_SENS_LH_MIN) begin
            sens_clamp = `LLJL_SENS_LH_MIN;
        end else if (s > lh_max) begin
            sens_clamp = lh_max;
        end else begin
            sens_clamp = s;
        end
    endfunction : sens_clamp

    function automatic logic rise(input logic now, input logic was);
        rise = now && !was;
    endfunction : rise

    // ==========================================================
    // pin synchronisers: two flops, then one more for edge finding
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
    logic [5:0] lvl_s1_reg, lvl_s2_reg;
    wire [NPIN-1:0] pins = {master_clock_i, tx_clock_in_i, tx_rail_i.p, tx_rail_i.n,
                            rx_clock_i, rx_line_in_p_i, rx_line_in_n_i};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
            pin_s3_reg <= '0;
            lvl_s1_reg <= 6'h3f;
            lvl_s2_reg <= 6'h3f;
        end else begin
            pin_s1_reg <= pins;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            lvl_s1_reg <= rx_level_db_i;
            lvl_s2_reg <= lvl_s1_reg;
        end
    end

    wire mclk_lvl = pin_s2_reg[6];
    wire mclk_edge = rise(pin_s2_reg[6], pin_s3_reg[6]);
    wire txc_edge = rise(pin_s2_reg[5], pin_s3_reg[5]);
    lljl_rail_t tx_frm;
    assign tx_frm = '{p: pin_s2_reg[4], n: pin_s2_reg[3]};
    wire rclk_lvl = pin_s2_reg[2];
    wire rclk_edge = rise(pin_s2_reg[2], pin_s3_reg[2]);
    lljl_rail_t rx_pin;
    assign rx_pin = '{p: pin_s2_reg[1], n: pin_s2_reg[0]};

    // ==========================================================
    // registers
    lljl_ctrl_t ctrl_reg;
    logic [15:0] latched_reg;
    logic [15:0] rdata_reg;
    lljl_los_state_t los_reg;
    logic los_d_reg;
    logic [7:0] fill;
    logic ja_trip;

    wire wr_ctrl = reg_we_i && (reg_addr_i == `LLJL_ADDR_CTRL);
    wire wr_lat = reg_we_i && (reg_addr_i == `LLJL_ADDR_LATCHED);
    wire [5:0] sens_w = sens_clamp(reg_wdata_i[`LLJL_CTRL_SENS_HI:`LLJL_CTRL_SENS_LO],
                                   reg_wdata_i[`LLJL_CTRL_E1]);
    wire [15:0] ctrl_w = {sens_w, 1'b0, reg_wdata_i[8:0]};
    wire los = (los_reg == LLJL_ST_LOSS);
    wire [15:0] lat_set = ({15'h0000, rise(los, los_d_reg)} << `LLJL_LAT_CARRIER_LOSS) |
                          ({15'h0000, ja_trip} << `LLJL_LAT_JITTER_TRIP);
    // set wins over a write-one-to-clear in the same cycle
    wire [15:0] lat_clr = wr_lat ? reg_wdata_i : 16'h0000;
    wire [15:0] latched_next = (latched_reg & ~lat_clr) | lat_set;
    wire [15:0] status = {1'b0, lvl_s2_reg, fill, los};
    wire [15:0] rd_mux = (reg_addr_i == `LLJL_ADDR_CTRL) ? ctrl_reg :
                         (reg_addr_i == `LLJL_ADDR_STATUS) ? status :
                         (reg_addr_i == `LLJL_ADDR_LATCHED) ? latched_reg : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `LLJL_CTRL_RESET;
            latched_reg <= `LLJL_LATCHED_RESET;
            rdata_reg <= 16'h0000;
            los_d_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_w;
            end
            latched_reg <= latched_next;
            rdata_reg <= reg_re_i ? rd_mux : 16'h0000;
            los_d_reg <= los;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign rx_carrier_loss_o = los;

    // ==========================================================
    // loopback routing
    logic txo_p_reg, txo_n_reg, txo_clk_reg;
    logic txo_edge_reg;
    wire alb = ctrl_reg.analog_loop_enable;
    wire loc = ctrl_reg.local_loop_enable;
    wire rem = ctrl_reg.remote_loop_enable;

    // line receiver input; in analog loop the line pins are ignored
    lljl_rail_t line_rx;
    assign line_rx = alb ? '{p: txo_p_reg, n: txo_n_reg} : rx_pin;
    wire line_edge = alb ? txo_edge_reg : rclk_edge;
    wire line_clk_lvl = alb ? txo_clk_reg : rclk_lvl;
    wire [5:0] line_lvl = alb ? 6'h00 : lvl_s2_reg;

    // receive path source: framer transmit data in local or dual loop
    lljl_rail_t rxp_data;
    assign rxp_data = loc ? tx_frm : line_rx;
    wire rxp_edge = loc ? txc_edge : line_edge;

    // transmit path source: received data in remote or dual loop
    lljl_rail_t txp_data;
    assign txp_data = rem ? line_rx : tx_frm;
    wire txp_edge = rem ? line_edge : txc_edge;

    // ==========================================================
    // jitter attenuator placement
    lljl_ja_path_t path;
    assign path = lljl_ja_path_t'({ctrl_reg.jitter_path_select_hi, ctrl_reg.jitter_path_select_lo});
    wire ja_rx = (path == LLJL_JA_RX);
    wire ja_tx = (path == LLJL_JA_TX);
    lljl_rail_t ja_in, ja_out;
    logic ja_rd, ja_rclk;
    assign ja_in = ja_tx ? txp_data : rxp_data;
    wire ja_wr = ja_tx ? txp_edge : (ja_rx ? rxp_edge : 1'b0);

    lljl_jitter_fifo #(
        .DEPTH(JA_DEPTH),
        .AW($clog2(JA_DEPTH))
    ) u_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .depth_long_i(ctrl_reg.jitter_depth_select),
        .e1_i(ctrl_reg.e1_mode),
        .wr_i(ja_wr),
        .wdata_i(ja_in),
        .rdata_o(ja_out),
        .rd_stb_o(ja_rd),
        .rclk_o(ja_rclk),
        .fill_o(fill),
        .trip_o(ja_trip)
    );

    // ==========================================================
    // loss of signal detector, one step per recovered bit period
    logic [11:0] win_reg, win_next;
    logic [7:0] ones_reg, ones_next;
    logic [6:0] zrun_reg, zrun_next;
    lljl_los_state_t los_next;
    wire [6:0] sens7 = {1'b0, ctrl_reg.sens_db};
    wire below_decl = ({1'b0, line_lvl} >= sens7 + `LLJL_HYST_DB);
    wire at_sens = ({1'b0, line_lvl} <= sens7);
    wire long_crit = ctrl_reg.e1_mode && ctrl_reg.crit_long;
    wire [11:0] need = long_crit ? `LLJL_LOS_LONG_BITS : `LLJL_LOS_WIN_BITS;
    wire good_one = at_sens && (line_rx.p || line_rx.n);
    wire [11:0] win_inc = win_reg + 12'h001;
    wire [7:0] ones_inc = ones_reg + {7'h00, good_one};
    wire [6:0] zrun_inc = good_one ? 7'h00 : zrun_reg + 7'h01;

    always_comb begin
        los_next = los_reg;
        win_next = win_reg;
        ones_next = ones_reg;
        zrun_next = zrun_reg;
        if (line_edge) begin
            unique case (los_reg)
                LLJL_ST_SIGNAL: begin
                    ones_next = 8'h00;
                    zrun_next = 7'h00;
                    if (!below_decl) begin
                        win_next = 12'h000;
                    end else if (win_inc == need) begin
                        los_next = LLJL_ST_LOSS;
                        win_next = 12'h000;
                    end else begin
                        win_next = win_inc;
                    end
                end
                LLJL_ST_LOSS: begin
                    if (ctrl_reg.e1_mode) begin
                        if (!at_sens) begin
                            win_next = 12'h000;
                        end else if (win_inc == `LLJL_LOS_WIN_BITS) begin
                            los_next = LLJL_ST_SIGNAL;
                            win_next = 12'h000;
                        end else begin
                            win_next = win_inc;
                        end
                    end else if (zrun_inc == `LLJL_ZERO_RUN_MAX) begin
                        win_next = 12'h000;
                        ones_next = 8'h00;
                        zrun_next = 7'h00;
                    end else if (win_inc == `LLJL_LOS_WIN_BITS) begin
                        if (ones_inc >= `LLJL_ONES_MIN) begin
                            los_next = LLJL_ST_SIGNAL;
                        end
                        win_next = 12'h000;
                        ones_next = 8'h00;
                        zrun_next = 7'h00;
                    end else begin
                        win_next = win_inc;
                        ones_next = ones_inc;
                        zrun_next = zrun_inc;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            los_reg <= LLJL_ST_SIGNAL;
            win_reg <= 12'h000;
            ones_reg <= 8'h00;
            zrun_reg <= 7'h00;
        end else begin
            los_reg <= los_next;
            win_reg <= win_next;
            ones_reg <= ones_next;
            zrun_reg <= zrun_next;
        end
    end

    // ==========================================================
    // receive outputs to the framer
    lljl_rail_t rxo_reg;
    logic rxo_clk_reg;
    wire rx_stb = ja_rx ? ja_rd : rxp_edge;
    wire rx_clk_src = los && !loc ? mclk_lvl :
                      ja_rx ? ja_rclk : (loc ? pin_s2_reg[5] : line_clk_lvl);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxo_reg <= '0;
            rxo_clk_reg <= 1'b0;
        end else begin
            if (rx_stb) begin
                rxo_reg <= ja_rx ? ja_out : rxp_data;
            end
            rxo_clk_reg <= rx_clk_src;
        end
    end

    assign rx_serial_data_o = rxo_reg;
    assign rx_clock_o = rxo_clk_reg;

    // ==========================================================
    // transmit line outputs; all ones alternates marks for a balanced line
    logic ais_pol_reg;
    wire ais = los && ctrl_reg.auto_all_ones_on_loss;
    wire tx_stb = ais ? mclk_edge : (ja_tx ? ja_rd : txp_edge);
    lljl_rail_t tx_bit;
    assign tx_bit = ais ? '{p: !ais_pol_reg, n: ais_pol_reg} : (ja_tx ? ja_out : txp_data);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txo_p_reg <= 1'b0;
            txo_n_reg <= 1'b0;
            txo_clk_reg <= 1'b0;
            txo_edge_reg <= 1'b0;
            ais_pol_reg <= 1'b0;
        end else begin
            if (tx_stb) begin
                txo_p_reg <= tx_bit.p;
                txo_n_reg <= tx_bit.n;
                ais_pol_reg <= ais ? !ais_pol_reg : 1'b0;
            end
            txo_clk_reg <= ais ? mclk_lvl : (ja_tx ? ja_rclk : (rem ? line_clk_lvl : pin_s2_reg[5]));
            txo_edge_reg <= tx_stb;
        end
    end

    assign tx_line_out_p_o = txo_p_reg;
    assign tx_line_out_n_o = txo_n_reg;
    assign tx_line_clock_o = txo_clk_reg;

endmodule : lljl_core
`default_nettype wire

// >>> hdl/lljl_regs.svh
// Purpose: offsets, field positions, reset values and counts of the line supervision block
// Assumes: 16-bit register data, 4-bit word address
// Notes: definitions only
`ifndef LLJL_REGS_SVH
`define LLJL_REGS_SVH

// ==========================================================
// register offsets
`define LLJL_ADDR_CTRL 4'h0
`define LLJL_ADDR_STATUS 4'h1
`define LLJL_ADDR_LATCHED 4'h2

// ==========================================================
// control register fields
`define LLJL_CTRL_E1 0
`define LLJL_CTRL_CRIT_LONG 1
`define LLJL_CTRL_DEPTH 2
`define LLJL_CTRL_PATH_LO 3
`define LLJL_CTRL_PATH_HI 4
`define LLJL_CTRL_LOCAL_LOOP 5
`define LLJL_CTRL_REMOTE_LOOP 6
`define LLJL_CTRL_ANALOG_LOOP 7
`define LLJL_CTRL_AUTO_AIS 8
`define LLJL_CTRL_SENS_LO 10
`define LLJL_CTRL_SENS_HI 15
`define LLJL_CTRL_RESET 16'h3010

// ==========================================================
// status and latched status fields
`define LLJL_STAT_LOS 0
`define LLJL_STAT_FILL_LO 1
`define LLJL_STAT_FILL_HI 8
`define LLJL_STAT_LEVEL_LO 9
`define LLJL_STAT_LEVEL_HI 14
`define LLJL_LAT_CARRIER_LOSS 0
`define LLJL_LAT_JITTER_TRIP 3
`define LLJL_LATCHED_RESET 16'h0000

// ==========================================================
// loss detection counts, in bit periods, and levels in dB of cable loss
`define LLJL_LOS_WIN_BITS 12'h0c0
`define LLJL_LOS_LONG_BITS 12'h800
`define LLJL_ONES_MIN 8'h18
`define LLJL_ZERO_RUN_MAX 7'h64
`define LLJL_HYST_DB 7'h03
`define LLJL_SENS_SH_MIN 6'h0c
`define LLJL_SENS_SH_MAX 6'h12
`define LLJL_SENS_LH_MIN 6'h1e
`define LLJL_SENS_LH_T1_MAX 6'h26
`define LLJL_SENS_LH_E1_MAX 6'h2d

// ==========================================================
// jitter attenuator
`define LLJL_JA_DEPTH_SHORT 8'h20
`define LLJL_JA_DEPTH_LONG 8'h80
`define LLJL_JA_LIMIT_SHORT 8'h1c
`define LLJL_JA_LIMIT_LONG 8'h78
`define LLJL_JA_SHIFT_T1 4'h6
`define LLJL_JA_SHIFT_E1 4'h9
`define LLJL_JA_PER_RESET 16'h01a0
`define LLJL_JA_SLACK 8'h04

`endif

// >>> hdl/lljl_pkg.sv
// Purpose: types shared by the line supervision block
// Assumes: nothing
// Notes: constants live in lljl_regs.svh
package lljl_pkg;

    // ==========================================================
    // types
    typedef enum logic [0:0] {
        LLJL_ST_SIGNAL = 1'b0,
        LLJL_ST_LOSS = 1'b1
    } lljl_los_state_t;

    typedef enum logic [1:0] {
        LLJL_JA_OFF = 2'b00,
        LLJL_JA_TX = 2'b01,
        LLJL_JA_RX = 2'b10,
        LLJL_JA_OFF2 = 2'b11
    } lljl_ja_path_t;

    typedef struct packed {
        logic p;
        logic n;
    } lljl_rail_t;

    typedef struct packed {
        logic [5:0] sens_db;
        logic unused9;
        logic auto_all_ones_on_loss;
        logic analog_loop_enable;
        logic remote_loop_enable;
        logic local_loop_enable;
        logic jitter_path_select_hi;
        logic jitter_path_select_lo;
        logic jitter_depth_select;
        logic crit_long;
        logic e1_mode;
    } lljl_ctrl_t;

endpackage : lljl_pkg

// >>> hdl/lljl_jitter_fifo.sv
// Purpose: jitter attenuator fifo with a smoothed read clock
// Assumes: wr_i is a one-cycle strobe per input bit
// Notes: read rate follows a low-pass average of the write period
`timescale 1ns/1ps
`default_nettype none
`include "lljl_regs.svh"

module lljl_jitter_fifo #(
    parameter int DEPTH = 128,
    parameter int AW = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic depth_long_i,
    input wire logic e1_i,
    input wire logic wr_i,
    input wire lljl_pkg::lljl_rail_t wdata_i,
    output lljl_pkg::lljl_rail_t rdata_o,
    output logic rd_stb_o,
    output logic rclk_o,
    output logic [7:0] fill_o,
    output logic trip_o
);
    import lljl_pkg::*;

    // ==========================================================
    // storage and pointers
    lljl_rail_t mem [DEPTH];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [7:0] fill_reg;
    logic [15:0] meas_reg, per_reg, rcnt_reg;
    logic trip_reg, cen_reg;

    wire [7:0] depth = depth_long_i ? `LLJL_JA_DEPTH_LONG : `LLJL_JA_DEPTH_SHORT;
    wire [7:0] limit = depth_long_i ? `LLJL_JA_LIMIT_LONG : `LLJL_JA_LIMIT_SHORT;
    wire [7:0] half = depth >> 1;
    wire [AW-1:0] wrap = AW'(depth - 8'h01);
    wire empty = (fill_reg == 8'h00);
    wire full = (fill_reg == depth);
    wire [3:0] shift = e1_i ? `LLJL_JA_SHIFT_E1 : `LLJL_JA_SHIFT_T1;

    // period average in 12.4 fixed point; a gapped input only stretches the average
    wire [15:0] meas_fx = {meas_reg[11:0], 4'h0};
    wire signed [16:0] per_err = $signed({1'b0, meas_fx}) - $signed({1'b0, per_reg});
    wire signed [16:0] per_step = per_err >>> shift;
    wire [15:0] per_new = 16'(($signed({1'b0, per_reg}) + per_step));
    // fill steering: drain faster when more than LLJL_JA_SLACK above half, slower when more than LLJL_JA_SLACK below
    wire [11:0] per_int = per_reg[15:4];
    wire [11:0] per_adj = (fill_reg > half + `LLJL_JA_SLACK) ? per_int - 12'h001 :
                          (fill_reg + `LLJL_JA_SLACK < half) ? per_int + 12'h001 : per_int;
    wire rd_tick = ({4'h0, per_adj} <= rcnt_reg + 16'h0001);
    wire do_rd = rd_tick && !empty && cen_reg;
    wire do_wr = wr_i && !full;
    wire [7:0] dev = (fill_reg > half) ? fill_reg - half : half - fill_reg;
    wire over = cen_reg && ({dev, 1'b0} > {1'b0, limit});

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
            fill_reg <= 8'h00;
            cen_reg <= 1'b0;
            meas_reg <= 16'h0000;
            per_reg <= `LLJL_JA_PER_RESET;
            rcnt_reg <= 16'h0000;
            trip_reg <= 1'b0;
        end else begin
            if (do_wr) begin
                mem[wp_reg] <= wdata_i;
                wp_reg <= (wp_reg == wrap) ? '0 : wp_reg + 1'b1;
            end
            if (do_rd) begin
                rp_reg <= (rp_reg == wrap) ? '0 : rp_reg + 1'b1;
            end
            fill_reg <= fill_reg + {7'h00, do_wr} - {7'h00, do_rd};
            meas_reg <= wr_i ? 16'h0001 : ((meas_reg == 16'h0fff) ? meas_reg : meas_reg + 16'h0001);
            if (wr_i) begin
                per_reg <= per_new;
            end
            rcnt_reg <= rd_tick ? 16'h0000 : rcnt_reg + 16'h0001;
            trip_reg <= (over || (wr_i && full)) && !trip_reg;
            cen_reg <= (cen_reg && !empty) || (fill_reg >= half);
        end
    end

    assign rdata_o = mem[rp_reg];
    assign rd_stb_o = do_rd;
    assign rclk_o = (rcnt_reg < {5'h00, per_adj[11:1]});
    assign fill_o = fill_reg;
    assign trip_o = trip_reg;

endmodule : lljl_jitter_fifo
`default_nettype wire

// >>> bench/lljl_core_sva.sv
// Purpose: port checker for the line supervision block
// Assumes: one clock domain, synchronous active high reset
// Notes: bit counts allow two bits of slack for the input synchronisers
`timescale 1ns/1ps
`default_nettype none
`include "lljl_regs.svh"
// ==========================================================
// checker
module lljl_core_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic rx_clock_i,
    input wire logic master_clock_i,
    input wire logic rx_clock_o,
    input wire logic tx_line_out_p_o,
    input wire logic tx_line_out_n_o,
    input wire logic rx_carrier_loss_o
);
    logic [2:0] sync_q;
    logic [7:0] bits_q;
    logic [3:0] age_q;
    logic [15:0] ctrl_q;
    // bit count restarts at every loss change so each window is measured alone
    always_ff @(posedge clk_i) begin
        sync_q <= {sync_q[1:0], rx_clock_i};
        if (rst_i || $changed(rx_carrier_loss_o)) bits_q <= 8'h00;
        else if (sync_q[1] && !sync_q[2] && bits_q != 8'hff) bits_q <= bits_q + 8'h01;
        if (rst_i || (rx_clock_i && !sync_q[0])) age_q <= 4'h0;
        else if (age_q != 4'hf) age_q <= age_q + 4'h1;
        if (rst_i) ctrl_q <= `LLJL_CTRL_RESET;
        else if (reg_we_i && reg_addr_i == 4'h0) ctrl_q <= reg_wdata_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence master_quiet_s;
        (rx_carrier_loss_o && $stable(master_clock_i)) [*7];
    endsequence
    sequence status_read_s;
        reg_re_i && reg_addr_i == 4'h1 && $stable(rx_carrier_loss_o) ##1 $stable(rx_carrier_loss_o);
    endsequence
    chk_reset_quiet: assert property ($past(rst_i) |-> !rx_carrier_loss_o && !rx_clock_o
        && !tx_line_out_p_o && !tx_line_out_n_o && reg_rdata_o == 16'h0000)
        else $error("outputs not cleared by reset");
    chk_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read answer");
    chk_ctrl_readback: assert property (reg_re_i && reg_addr_i == 4'h0 |=>
        reg_rdata_o[9:0] == {1'b0, $past(ctrl_q[8:0])}) else $error("control readback wrong");
    chk_status_live: assert property (status_read_s |->
        reg_rdata_o[0] == rx_carrier_loss_o && !reg_rdata_o[15]) else $error("status loss bit wrong");
    chk_loss_on_edge: assert property ($rose(rx_carrier_loss_o) |-> age_q <= 4'h8)
        else $error("loss declared away from a bit edge");
    chk_declare_window: assert property ($rose(rx_carrier_loss_o) |-> bits_q >= 8'd190)
        else $error("loss declared before 192 bits");
    chk_clear_window: assert property ($fell(rx_carrier_loss_o) |-> bits_q >= 8'd190)
        else $error("loss cleared before 192 bits");
    chk_rxclk_master: assert property (master_quiet_s |-> $stable(rx_clock_o))
        else $error("receive clock not from master during loss");
endmodule : lljl_core_sva
bind lljl_core lljl_core_sva i_sva (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .rx_clock_i, .master_clock_i, .rx_clock_o, .tx_line_out_p_o,
    .tx_line_out_n_o, .rx_carrier_loss_o);
`default_nettype wire

// >>> bench/lljl_line_model.sv
// Purpose: line side model driving the receive pins
// Assumes: one bit every 8 system clocks, 200 ns
// Notes: line clock rests low between bursts, marks alternate between rails
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// line model
module lljl_line_model (
    input wire logic clk_i,
    output logic rx_clock_o,
    output logic rx_p_o,
    output logic rx_n_o,
    output logic [5:0] level_o
);
    initial begin
        rx_clock_o = 1'b0;
        rx_p_o = 1'b0;
        rx_n_o = 1'b0;
        level_o = 6'h00;
    end
    task automatic send(input int nb, input logic [5:0] lvl, input logic mark);
        for (int i = 0; i < nb; i++) begin
            @(posedge clk_i);
            level_o <= lvl;
            rx_p_o <= mark & ~i[0];
            rx_n_o <= mark & i[0];
            repeat (3) @(posedge clk_i);
            rx_clock_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            rx_clock_o <= 1'b0;
        end
    endtask : send
endmodule : lljl_line_model
`default_nettype wire

// >>> bench/testbench.sv
// Purpose: self-checking bench for the line supervision block
// Assumes: line model drives the receive pins, the bench plays the framer
// Notes: loss is looked at six cycles after the line clock stops
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// testbench
module testbench;
    import lljl_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0;
    logic master_clock_i = 1'b0, tx_clock_in_i = 1'b0, rx_clk, rx_p, rx_n;
    logic rx_clock_o, tx_line_out_p_o, tx_line_out_n_o, tx_line_clock_o, rx_carrier_loss_o;
    logic [3:0] reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, rv;
    logic [5:0] lvl;
    logic [2:0] seen, div = 3'h0;
    lljl_rail_t tx_rail_i = '0, rx_serial_data_o;
    int miscompares = 0, total_checks = 0;
    logic [15:0] cw [4] = '{16'h1400, 16'h5000, 16'hc800, 16'hc801};
    logic [15:0] ce [4] = '{16'h3000, 16'h7800, 16'h9800, 16'hb401};
    lljl_line_model line (.clk_i, .rx_clock_o(rx_clk), .rx_p_o(rx_p), .rx_n_o(rx_n), .level_o(lvl));
    lljl_core i_dut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
        .rx_line_in_p_i(rx_p), .rx_line_in_n_i(rx_n), .rx_clock_i(rx_clk), .rx_level_db_i(lvl),
        .tx_rail_i, .tx_clock_in_i, .master_clock_i, .rx_serial_data_o, .rx_clock_o,
        .tx_line_out_p_o, .tx_line_out_n_o, .tx_line_clock_o, .rx_carrier_loss_o);
    initial forever #12.5 clk_i = ~clk_i;
    initial forever #244.140 master_clock_i = ~master_clock_i;
    // framer clock runs free, the framer has no reason to gap it here
    always @(posedge clk_i) begin
        div <= div + 3'h1;
        tx_clock_in_i <= div[2];
    end
    task automatic wrap_up();
        if (miscompares == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    task automatic ck(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : ck
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_we_i <= 1'b1;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_re_i <= 1'b1;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 rv = reg_rdata_o;
    endtask : rd
    task automatic lc(input logic e);
        repeat (6) @(posedge clk_i);
        #1 ck("loss", {15'h0, e}, {15'h0, rx_carrier_loss_o});
    endtask : lc
    // seen holds transmit mark, receive mark, both clocks high
    task automatic watch(input int n);
        seen = 3'b000;
        repeat (n) begin
            @(posedge clk_i);
            #1 seen = seen | {tx_line_out_p_o | tx_line_out_n_o,
                rx_serial_data_o.p | rx_serial_data_o.n, rx_clock_o & tx_line_clock_o};
        end
    endtask : watch
    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0);
        ck("ctrl reset", 16'h3010, rv);
        rd(4'h2);
        ck("latched reset", 16'h0000, rv);
        rd(4'h5);
        ck("unmapped", 16'h0000, rv);
        for (int i = 0; i < 4; i++) begin
            wr(4'h0, cw[i]);
            rd(4'h0);
            ck("sensitivity clamp", ce[i], rv);
        end
        wr(4'h0, 16'h3000);
        line.send(300, 6'h0e, 1'b1);
        lc(1'b0);
        line.send(191, 6'h0f, 1'b1);
        lc(1'b0);
        line.send(1, 6'h0f, 1'b1);
        lc(1'b1);
        rd(4'h2);
        ck("latched loss", 16'h0001, rv & 16'h0001);
        wr(4'h2, 16'h0001);
        rd(4'h2);
        ck("latched clear", 16'h0000, rv & 16'h0001);
        rd(4'h1);
        ck("status loss", 16'h0001, rv & 16'h8001);
        watch(80);
        ck("no all ones", 16'h0000, {15'h0, seen[2]});
        wr(4'h0, 16'h3100);
        watch(80);
        ck("all ones", 16'h0005, {13'h0, seen[2], 1'b0, seen[0]});
        wr(4'h0, 16'h3000);
        line.send(400, 6'h0d, 1'b1);
        lc(1'b1);
        line.send(23, 6'h0c, 1'b1);
        lc(1'b1);
        line.send(200, 6'h0c, 1'b1);
        lc(1'b0);
        wr(4'h0, 16'h3003);
        line.send(2047, 6'h10, 1'b1);
        lc(1'b0);
        line.send(1, 6'h10, 1'b1);
        lc(1'b1);
        line.send(191, 6'h0c, 1'b0);
        lc(1'b1);
        line.send(1, 6'h0c, 1'b0);
        lc(1'b0);
        wr(4'h0, 16'h3040);
        fork
            line.send(20, 6'h00, 1'b1);
            watch(170);
        join
        ck("remote", 16'h0001, {15'h0, seen[2]});
        tx_rail_i <= '{p: 1'b1, n: 1'b0};
        wr(4'h0, 16'h3020);
        watch(80);
        ck("local", 16'h0003, {14'h0, seen[2:1]});
        wr(4'h0, 16'h3060);
        line.send(3, 6'h00, 1'b0);
        fork
            line.send(20, 6'h00, 1'b0);
            watch(170);
        join
        ck("dual", 16'h0001, {14'h0, seen[2:1]});
        wr(4'h0, 16'h3008);
        watch(300);
        rd(4'h1);
        ck("jitter tx path", 16'h0003, {14'h0, seen[2], |rv[8:1]});
        wr(4'h0, 16'h3080);
        watch(80);
        ck("analog", 16'h0003, {14'h0, seen[2:1]});
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
